/* core/caf_map.svh */
// register map, field positions and reset values for the alu flag and reset cause block
// Function
// - flag-affecting instruction targeting alu_flags updates flags only, result discarded
// - subtraction carry and digit carry act as inverted borrow
// - alu_flags bits 7 to 5 read as zero
// - negative flag, bit 4, copies result msb
// - overflow flag, bit 3, set when signed result changes sign wrongly
// - zero flag, bit 2, set when result is zero
// - add/sub digit carry, bit 1, is carry out of low nibble
// - rotates load digit carry from source bit 4 or bit 3
// - carry, bit 0, is carry out of msb; rotates take shifted-out bit
// - irq priority enable, bit 7, enables two levels; resets to zero
// - soft reset flag, bit 4, cleared by reset instruction, set by firmware
// - watchdog timeout flag set by power-up, clear or sleep; timeout clears it
// - power down flag set by power-up or clear; sleep clears it
// - power-on flag, bit 1, zero after power-on, firmware sets it
// - brown-out flag cleared by brown-out, reads one after power-on if enabled
// - reset_cause_flags bits 6 and 5 read as zero
// - reset_cause_flags writable except timeout and power down flags
`ifndef CAF_MAP_SVH
`define CAF_MAP_SVH
// ======================================
// bus offsets
`define CAF_OFF_ALU_FLAGS 32'h0000_0000
`define CAF_OFF_RESET_CAUSE 32'h0000_0004
`define CAF_HTRANS_NONSEQ 2'h2
// ======================================
// alu flag fields
`define CAF_BIT_N 4
`define CAF_BIT_OV 3
`define CAF_BIT_Z 2
`define CAF_BIT_DC 1
`define CAF_BIT_C 0
`define CAF_ALU_RST 5'h00
// ======================================
// reset cause fields
`define CAF_BIT_IRQ_PRIORITY_ENABLE 7
`define CAF_BIT_RI 4
`define CAF_BIT_TO 3
`define CAF_BIT_PD 2
`define CAF_BIT_POR 1
`define CAF_BIT_BOR 0
`define CAF_RC_RST 8'h1c
`define CAF_RC_SW_MASK 8'h93
`endif

/* core/caf_pkg.sv */
// types shared by the alu flag and reset cause block
package caf_pkg;
  typedef logic [7:0] caf_byte_t;
  typedef logic [4:0] caf_flags_t;
  typedef enum logic [8:0]
  {
    CAF_OP_ADD = 9'h001,
    CAF_OP_SUB = 9'h002,
    CAF_OP_ROTL = 9'h004,
    CAF_OP_ROTR = 9'h008,
    CAF_OP_AND = 9'h010,
    CAF_OP_IOR = 9'h020,
    CAF_OP_XOR = 9'h040,
    CAF_OP_CLEAR = 9'h080,
    CAF_OP_MOVE = 9'h100
  } caf_op_e;
endpackage

/* core/caf_flag_regs.sv */
// alu flag register and reset cause register with ahb-lite access
`timescale 1ns/1ps
`include "caf_map.svh"
module caf_flag_regs
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic exec_valid,
  input wire caf_pkg::caf_op_e exec_op,
  input wire caf_pkg::caf_byte_t exec_a,
  input wire caf_pkg::caf_byte_t exec_b,
  input wire logic exec_to_flags,
  output caf_pkg::caf_byte_t exec_result,
  output logic exec_result_valid,
  output caf_pkg::caf_byte_t alu_flags,
  output caf_pkg::caf_byte_t reset_cause_flags,
  output logic irq_priority_enable,
  input wire logic cfg_brown_out_enable,
  input wire logic evt_soft_reset,
  input wire logic evt_brown_out,
  input wire logic evt_wdt_timeout,
  input wire logic evt_watchdog_clear,
  input wire logic evt_sleep
);
  import caf_pkg::*;

  // ======================================
  // ahb-lite slave, zero wait states
  logic addr_take;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic wr_alu;
  logic wr_rc;
  caf_byte_t rd_val;

  assign addr_take = hsel && hready && htrans[1];
  assign wr_alu = wr_pend && (wr_addr == `CAF_OFF_ALU_FLAGS);
  assign wr_rc = wr_pend && (wr_addr == `CAF_OFF_RESET_CAUSE);

  always_comb
  begin
    rd_val = 8'h00;
    if (haddr == `CAF_OFF_ALU_FLAGS)
      rd_val = alu_flags;
    else if (haddr == `CAF_OFF_RESET_CAUSE)
      rd_val = reset_cause_flags;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0000_0000;
    end
    else
    begin
      wr_pend <= addr_take && hwrite;
      if (addr_take)
        wr_addr <= haddr;
    end
  end

  // read data is sampled in the address phase; an unmapped word reads zero
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_take && !hwrite)
        hrdata <= {24'h00_0000, rd_val};
    end
  end

  // ======================================
  // flag calculation
  logic [8:0] sum;
  logic [4:0] nib;
  caf_byte_t res;
  caf_flags_t calc;
  caf_flags_t aff;
  caf_flags_t cur;
  caf_flags_t next_flags;

  assign cur = alu_flags[4:0];

  always_comb
  begin
    sum = 9'h000;
    nib = 5'h00;
    res = 8'h00;
    calc = cur;
    aff = 5'h00;
    unique case (exec_op)
      CAF_OP_ADD:
      begin
        sum = {1'b0, exec_a} + {1'b0, exec_b};
        nib = {1'b0, exec_a[3:0]} + {1'b0, exec_b[3:0]};
        res = sum[7:0];
        calc[`CAF_BIT_C] = sum[8];
        calc[`CAF_BIT_DC] = nib[4];
        calc[`CAF_BIT_OV] = (exec_a[7] == exec_b[7]) && (res[7] != exec_a[7]);
        aff = 5'h1f;
      end
      CAF_OP_SUB:
      begin
        // two's complement add, so carry and digit carry come out as not-borrow
        sum = {1'b0, exec_a} + {1'b0, ~exec_b} + 9'h001;
        nib = {1'b0, exec_a[3:0]} + {1'b0, ~exec_b[3:0]} + 5'h01;
        res = sum[7:0];
        calc[`CAF_BIT_C] = sum[8];
        calc[`CAF_BIT_DC] = nib[4];
        calc[`CAF_BIT_OV] = (exec_a[7] != exec_b[7]) && (res[7] != exec_a[7]);
        aff = 5'h1f;
      end
      CAF_OP_ROTL:
      begin
        res = {exec_a[6:0], cur[`CAF_BIT_C]};
        calc[`CAF_BIT_C] = exec_a[7];
        calc[`CAF_BIT_DC] = exec_a[3];
        aff = 5'h17;
      end
      CAF_OP_ROTR:
      begin
        res = {cur[`CAF_BIT_C], exec_a[7:1]};
        calc[`CAF_BIT_C] = exec_a[0];
        calc[`CAF_BIT_DC] = exec_a[4];
        aff = 5'h17;
      end
      CAF_OP_AND:
      begin
        res = exec_a & exec_b;
        aff = 5'h14;
      end
      CAF_OP_IOR:
      begin
        res = exec_a | exec_b;
        aff = 5'h14;
      end
      CAF_OP_XOR:
      begin
        res = exec_a ^ exec_b;
        aff = 5'h14;
      end
      CAF_OP_CLEAR:
      begin
        res = 8'h00;
        aff = 5'h04;
      end
      CAF_OP_MOVE:
      begin
        res = exec_a;
        aff = 5'h00;
      end
      default:
      begin
        res = 8'h00;
        aff = 5'h00;
      end
    endcase
    calc[`CAF_BIT_N] = res[7];
    calc[`CAF_BIT_Z] = (res == 8'h00);
  end

  // exec wins over a bus write landing in the same cycle
  always_comb
  begin
    next_flags = cur;
    if (exec_valid)
    begin
      if (exec_to_flags && (aff == 5'h00))
        next_flags = res[4:0];
      else
        next_flags = (cur & ~aff) | (calc & aff);
    end
    else if (wr_alu)
      next_flags = hwdata[4:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      alu_flags <= {3'b000, `CAF_ALU_RST};
    else
      alu_flags <= {3'b000, next_flags};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      exec_result <= 8'h00;
      exec_result_valid <= 1'b0;
    end
    else
    begin
      exec_result <= res;
      exec_result_valid <= exec_valid && !exec_to_flags;
    end
  end

  // ======================================
  // reset cause register
  logic bor_strap;
  caf_byte_t next_rc;

  // strap taken one cycle after release, never inside the reset branch
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      bor_strap <= 1'b1;
    else
      bor_strap <= 1'b0;
  end

  // hardware events are applied after the bus write so none is lost
  always_comb
  begin
    next_rc = reset_cause_flags;
    if (wr_rc)
      next_rc = (reset_cause_flags & ~`CAF_RC_SW_MASK) | (hwdata[7:0] & `CAF_RC_SW_MASK);
    if (bor_strap)
      next_rc[`CAF_BIT_BOR] = cfg_brown_out_enable;
    if (evt_soft_reset)
      next_rc[`CAF_BIT_RI] = 1'b0;
    if (evt_brown_out)
      next_rc[`CAF_BIT_BOR] = 1'b0;
    if (evt_watchdog_clear)
    begin
      next_rc[`CAF_BIT_TO] = 1'b1;
      next_rc[`CAF_BIT_PD] = 1'b1;
    end
    if (evt_sleep)
    begin
      next_rc[`CAF_BIT_TO] = 1'b1;
      next_rc[`CAF_BIT_PD] = 1'b0;
    end
    if (evt_wdt_timeout)
      next_rc[`CAF_BIT_TO] = 1'b0;
    next_rc[6:5] = 2'b00;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      reset_cause_flags <= `CAF_RC_RST;
      irq_priority_enable <= 1'b0;
    end
    else
    begin
      reset_cause_flags <= next_rc;
      irq_priority_enable <= next_rc[`CAF_BIT_IRQ_PRIORITY_ENABLE];
    end
  end

  // ======================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  alu_upper_zero_a: assert property (alu_flags[7:5] == 3'b000)
    else $error("alu flag upper bits not zero");
  rc_unimpl_zero_a: assert property (reset_cause_flags[6:5] == 2'b00)
    else $error("reset cause bits 6 and 5 not zero");
  add_zero_carry_a: assert property (exec_valid && exec_op == CAF_OP_ADD |=>
    alu_flags[`CAF_BIT_Z] == (exec_result == 8'h00)
    && alu_flags[`CAF_BIT_C] == (({1'b0, $past(exec_a)} + {1'b0, $past(exec_b)}) > 9'h0ff))
    else $error("add zero or carry flag wrong");
  sub_borrow_flag_a: assert property (exec_valid && exec_op == CAF_OP_SUB |=>
    alu_flags[`CAF_BIT_C] == ($past(exec_a) >= $past(exec_b)))
    else $error("subtract borrow polarity wrong");
  neg_follows_msb_a: assert property (exec_valid && !exec_to_flags
    && (exec_op == CAF_OP_ADD || exec_op == CAF_OP_XOR) |=> alu_flags[`CAF_BIT_N] == exec_result[7])
    else $error("negative flag does not follow msb");
  ovf_sign_a: assert property (exec_valid && exec_op == CAF_OP_ADD && !exec_to_flags |=>
    alu_flags[`CAF_BIT_OV] == ($past(exec_a[7]) == $past(exec_b[7])
    && exec_result[7] != $past(exec_a[7])))
    else $error("overflow flag wrong");
  rotr_digit_a: assert property (exec_valid && exec_op == CAF_OP_ROTR |=>
    alu_flags[`CAF_BIT_DC] == $past(exec_a[4]) && alu_flags[`CAF_BIT_C] == $past(exec_a[0]))
    else $error("rotate right digit carry or carry wrong");
  clear_dest_a: assert property (exec_valid && exec_to_flags && exec_op == CAF_OP_CLEAR |=>
    alu_flags[`CAF_BIT_Z] && !exec_result_valid
    && {alu_flags[4:3], alu_flags[1:0]} == $past({alu_flags[4:3], alu_flags[1:0]}))
    else $error("clear into flags wrote the result");
  move_dest_a: assert property (exec_valid && exec_to_flags && exec_op == CAF_OP_MOVE |=>
    alu_flags == {3'b000, $past(exec_a[4:0])})
    else $error("move into flags not stored");
  timeout_clear_a: assert property (evt_wdt_timeout |=> !reset_cause_flags[`CAF_BIT_TO])
    else $error("watchdog timeout did not clear flag");
  sleep_pd_a: assert property (evt_sleep |=> !reset_cause_flags[`CAF_BIT_PD])
    else $error("sleep did not clear power down flag");
  soft_reset_a: assert property (evt_soft_reset |=> !reset_cause_flags[`CAF_BIT_RI])
    else $error("reset instruction flag not cleared");
  por_after_reset_a: assert property ($rose(reset_n) |-> !reset_cause_flags[`CAF_BIT_POR]
    && !irq_priority_enable ##1 reset_cause_flags[`CAF_BIT_BOR] == $past(cfg_brown_out_enable)
    || $past(evt_brown_out))
    else $error("power-on values wrong");
  ro_bits_kept_a: assert property (wr_rc && !evt_wdt_timeout && !evt_sleep
    && !evt_watchdog_clear |=> $stable(reset_cause_flags[3:2]))
    else $error("software write changed read-only flags");
  rd_alu_path_a: assert property (addr_take && !hwrite && haddr == `CAF_OFF_ALU_FLAGS |=>
    hrdata == {27'h000_0000, $past(alu_flags[4:0])})
    else $error("alu flag read-back wrong");
  rd_rc_path_a: assert property (addr_take && !hwrite
    && haddr == `CAF_OFF_RESET_CAUSE |=>
    hrdata == {24'h00_0000, $past(reset_cause_flags[`CAF_BIT_IRQ_PRIORITY_ENABLE]),
    2'b00, $past(reset_cause_flags[4:0])})
    else $error("reset cause read-back wrong");
  bus_flag_write_a: assert property (wr_alu && !exec_valid |=>
    alu_flags == {3'b000, $past(hwdata[4:0])})
    else $error("bus write to alu flags not stored");
  irq_priority_enable_copy_a: assert property (irq_priority_enable == reset_cause_flags[`CAF_BIT_IRQ_PRIORITY_ENABLE])
    else $error("priority enable output differs from register bit");
  rotl_digit_a: assert property (exec_valid && exec_op == CAF_OP_ROTL |=>
    alu_flags[`CAF_BIT_DC] == $past(exec_a[3]) && alu_flags[`CAF_BIT_C] == $past(exec_a[7]))
    else $error("rotate left digit carry or carry wrong");
  logic_keeps_a: assert property (exec_valid && exec_op == CAF_OP_AND |=>
    $stable({alu_flags[`CAF_BIT_OV], alu_flags[`CAF_BIT_DC], alu_flags[`CAF_BIT_C]}))
    else $error("logic op changed carry flags");

  sub_seen_c: cover property (exec_valid && exec_op == CAF_OP_SUB ##1 !alu_flags[`CAF_BIT_C]);
  dest_seen_c: cover property (exec_valid && exec_to_flags && exec_op == CAF_OP_ADD);
  sleep_wake_c: cover property (evt_sleep ##[1:20] evt_wdt_timeout);
  bus_rc_c: cover property (wr_rc ##1 reset_cause_flags[`CAF_BIT_POR]);
  bor_off_c: cover property ($rose(reset_n) ##1 !reset_cause_flags[`CAF_BIT_BOR]);
endmodule

/* verification/caf_core_model.sv */
// far-side model: instruction execution and reset/watchdog event sources
`timescale 1ns/1ps
module caf_core_model
(
  input wire logic clk_sys,
  output logic exec_valid,
  output caf_pkg::caf_op_e exec_op,
  output caf_pkg::caf_byte_t exec_a,
  output caf_pkg::caf_byte_t exec_b,
  output logic exec_to_flags,
  output logic [4:0] evt
);
  import caf_pkg::*;
  initial
  begin
    exec_valid = 1'b0;
    exec_op = CAF_OP_MOVE;
    exec_a = 8'h00;
    exec_b = 8'h00;
    exec_to_flags = 1'b0;
    evt = 5'h00;
  end
  // ======================================
  // one instruction; operands flip after use so stale values never look valid
  task automatic issue(input caf_op_e op, input caf_byte_t a, b, input logic tf);
    @(posedge clk_sys);
    exec_valid <= 1'b1;
    exec_op <= op;
    exec_a <= a;
    exec_b <= b;
    exec_to_flags <= tf;
    @(posedge clk_sys);
    exec_valid <= 1'b0;
    exec_to_flags <= 1'b0;
    exec_a <= ~a;
    exec_b <= ~b;
  endtask
  // ======================================
  // event pulse: 0 soft reset, 1 brown-out, 2 timeout, 3 clear, 4 sleep
  task automatic pulse(input int unsigned i);
    @(posedge clk_sys);
    evt[i] <= 1'b1;
    @(posedge clk_sys);
    evt <= 5'h00;
  endtask
endmodule

/* verification/test_core_alu_flags_and_reset_cause.sv */
// self-checking bench for the alu flag and reset cause register block
`timescale 1ns/1ps
`include "caf_map.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_core_alu_flags_and_reset_cause;
  import caf_pkg::*;
  logic clk_sys, reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans;
  logic exec_valid, exec_to_flags, exec_result_valid, irq_priority_enable;
  caf_op_e exec_op;
  caf_byte_t exec_a, exec_b, exec_result, alu_flags, reset_cause_flags;
  logic [4:0] evt;
  logic cfg_bor;
  int errors = 0;
  int tests_run = 0;
  assign hready = hreadyout;
  caf_flag_regs i_dut
  (
    .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .exec_valid(exec_valid),
    .exec_op(exec_op), .exec_a(exec_a), .exec_b(exec_b), .exec_to_flags(exec_to_flags),
    .exec_result(exec_result), .exec_result_valid(exec_result_valid),
    .alu_flags(alu_flags), .reset_cause_flags(reset_cause_flags),
    .irq_priority_enable(irq_priority_enable), .cfg_brown_out_enable(cfg_bor),
    .evt_soft_reset(evt[0]), .evt_brown_out(evt[1]), .evt_wdt_timeout(evt[2]),
    .evt_watchdog_clear(evt[3]), .evt_sleep(evt[4])
  );
  caf_core_model i_core
  (
    .clk_sys(clk_sys), .exec_valid(exec_valid), .exec_op(exec_op), .exec_a(exec_a),
    .exec_b(exec_b), .exec_to_flags(exec_to_flags), .evt(evt)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ======================================
  // bus master: address phase held until hready, then data phase
  task automatic xfer(input logic w, input logic [31:0] a, d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= `CAF_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK("hrdata", e, rdat)
    `CHK("hresp", 1'b0, hresp)
    `CHK("hreadyout", 1'b1, hreadyout)
  endtask
  task automatic ex(input caf_op_e op, input caf_byte_t a, b, input logic tf,
                    input caf_byte_t f, r);
    i_core.issue(op, a, b, tf);
    #1;
    `CHK("alu_flags", f, alu_flags)
    `CHK("result_valid", ~tf, exec_result_valid)
    if (!tf) `CHK("exec_result", r, exec_result)
  endtask
  task automatic ev(input int unsigned i, input caf_byte_t e);
    i_core.pulse(i);
    #1;
    `CHK("reset_cause_flags", e, reset_cause_flags)
  endtask
  // ======================================
  // scenarios
  task automatic t_reset();
    rd(`CAF_OFF_ALU_FLAGS, 32'h0);
    rd(`CAF_OFF_RESET_CAUSE, 32'h1d);
    `CHK("irq_priority_enable", 1'b0, irq_priority_enable)
    rd(32'h8, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_arith();
    ex(CAF_OP_ADD, 8'h7f, 8'h01, 1'b0, 8'h1a, 8'h80);
    ex(CAF_OP_ADD, 8'hff, 8'h01, 1'b0, 8'h07, 8'h00);
    ex(CAF_OP_SUB, 8'h00, 8'h01, 1'b0, 8'h10, 8'hff);
    ex(CAF_OP_SUB, 8'h05, 8'h03, 1'b0, 8'h03, 8'h02);
    ex(CAF_OP_SUB, 8'h80, 8'h01, 1'b0, 8'h09, 8'h7f);
    $display("test arith done");
  endtask
  task automatic t_rotate();
    xfer(1'b1, `CAF_OFF_ALU_FLAGS, 32'h0);
    ex(CAF_OP_ROTL, 8'h88, 8'h00, 1'b0, 8'h03, 8'h10);
    ex(CAF_OP_ROTR, 8'h11, 8'h00, 1'b0, 8'h13, 8'h88);
    $display("test rotate done");
  endtask
  // logic ops touch only negative and zero; carry flags must ride through
  task automatic t_logic();
    ex(CAF_OP_AND, 8'hf0, 8'h0f, 1'b0, 8'h07, 8'h00);
    ex(CAF_OP_IOR, 8'h80, 8'h01, 1'b0, 8'h13, 8'h81);
    ex(CAF_OP_XOR, 8'h5a, 8'h5a, 1'b0, 8'h07, 8'h00);
    $display("test logic done");
  endtask
  // second power-on with brown-out detection off: flag must stay clear
  task automatic t_bor_off();
    @(posedge clk_sys);
    cfg_bor <= 1'b0;
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("hrdata", 32'h0, hrdata)
    `CHK("hreadyout", 1'b1, hreadyout)
    `CHK("exec_result", 8'h00, exec_result)
    `CHK("alu_flags", 8'h00, alu_flags)
    @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(`CAF_OFF_RESET_CAUSE, 32'h1c);
    rd(`CAF_OFF_ALU_FLAGS, 32'h0);
    `CHK("irq_priority_enable", 1'b0, irq_priority_enable)
    $display("test brown-out disabled reset done");
  endtask
  task automatic t_dest();
    xfer(1'b1, `CAF_OFF_ALU_FLAGS, 32'h0b);
    ex(CAF_OP_CLEAR, 8'h55, 8'h00, 1'b1, 8'h0f, 8'h00);
    ex(CAF_OP_MOVE, 8'hf5, 8'h00, 1'b1, 8'h15, 8'h00);
    rd(`CAF_OFF_ALU_FLAGS, 32'h15);
    ex(CAF_OP_ADD, 8'h88, 8'h88, 1'b1, 8'h0b, 8'h00);
    $display("test destination done");
  endtask
  task automatic t_cause();
    xfer(1'b1, `CAF_OFF_RESET_CAUSE, 32'hff);
    rd(`CAF_OFF_RESET_CAUSE, 32'h9f);
    `CHK("irq_priority_enable", 1'b1, irq_priority_enable)
    ev(4, 8'h9b);
    ev(2, 8'h93);
    ev(3, 8'h9f);
    ev(0, 8'h8f);
    ev(1, 8'h8e);
    xfer(1'b1, `CAF_OFF_RESET_CAUSE, 32'h00);
    rd(`CAF_OFF_RESET_CAUSE, 32'h0c);
    $display("test reset cause done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    reset_n = 1'b0;
    cfg_bor = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_arith();
    t_rotate();
    t_logic();
    t_dest();
    t_cause();
    t_bor_off();
    give_verdict();
  end
  // hang guard: whole run needs under a hundred cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    give_verdict();
  end
endmodule
